// >>> pkg/arseq_map.vh
// Constants for the automatic reclose sequencer
`ifndef ARSEQ_MAP_VH
`define ARSEQ_MAP_VH

// Register byte offsets
`define ARSEQ_OFS_CTRL 8'h00
`define ARSEQ_OFS_DT_SP 8'h04
`define ARSEQ_OFS_DT_TP 8'h08
`define ARSEQ_OFS_DT_2P 8'h0c
`define ARSEQ_OFS_RECLAIM 8'h10
`define ARSEQ_OFS_STATUS 8'h14

// Control field positions
`define ARSEQ_CTRL_EN 0
`define ARSEQ_CTRL_PROG_LO 1
`define ARSEQ_CTRL_PROG_HI 2
`define ARSEQ_CTRL_TP_ALLOW 3
`define ARSEQ_CTRL_SP_OPT 4
`define ARSEQ_CTRL_TWO_PH 5
`define ARSEQ_CTRL_FORCED 6
`define ARSEQ_CTRL_PICKUP 7
`define ARSEQ_CTRL_SHOT_LO 8
`define ARSEQ_CTRL_SHOT_HI 11
`define ARSEQ_CTRL_CLEAR 12
`define ARSEQ_CTRL_PER_POLE 13

// Program codes
`define ARSEQ_PROG_3P 2'h0
`define ARSEQ_PROG_1P 2'h1
`define ARSEQ_PROG_13P 2'h2

// Reset values
`define ARSEQ_RST_CTRL 32'h00000108
`define ARSEQ_RST_DT_SP 16'h0064
`define ARSEQ_RST_DT_TP 16'h012c
`define ARSEQ_RST_DT_2P 16'h00c8
`define ARSEQ_RST_RECLAIM 16'h0bb8

// Timing
`define ARSEQ_CLK_MHZ 20
`define ARSEQ_TICK_US 1000
`define ARSEQ_TICK_CYC (`ARSEQ_TICK_US * `ARSEQ_CLK_MHZ)
`define ARSEQ_LOCK_MS 500
`define ARSEQ_LOCK_TICKS ((`ARSEQ_LOCK_MS * 1000) / `ARSEQ_TICK_US)
`define ARSEQ_MAX_SHOTS 8

`endif

// >>> rtl/arseq_timer.v
// Tick-based down counter shared by dead, reclaim and lockout times
module arseq_timer #(
  parameter TW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire clear,
  input wire tick,
  input wire load,
  input wire [TW-1:0] load_val,
  // Result
  output reg done
);

  reg [TW-1:0] cnt_r;
  reg run_r;

  // Load restarts; done pulses once when count reaches zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {TW{1'b0}};
      run_r <= 1'b0;
      done <= 1'b0;
    end else if (clear) begin
      cnt_r <= {TW{1'b0}};
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
        run_r <= 1'b1;
      end else if (run_r && cnt_r == {TW{1'b0}}) begin
        run_r <= 1'b0;
        done <= 1'b1;
      end else if (run_r && tick) begin
        cnt_r <= cnt_r - {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // arseq_timer

// >>> rtl/arseq_top.v
// Automatic reclose sequencer with APB register slave
`include "arseq_map.vh"

module arseq_top #(
  parameter TICK_CYC = `ARSEQ_TICK_CYC,
  parameter TW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Protection side
  input wire prot_trip,
  input wire prot_phase_sel,
  input wire [2:0] pick_phase,
  input wire pick_earth,
  input wire ar_block,
  // Breaker auxiliary contacts
  input wire [2:0] cb_pole_closed,
  input wire cb_3p_closed,
  input wire cb_3p_open,
  // Breaker commands and status
  output reg [2:0] trip_pole,
  output reg close_cmd,
  output reg final_trip,
  output reg ar_lockout,
  output reg ar_running,
  output reg ar_ready
);

  // One-hot sequence states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_TRIP = 5'h02;
  localparam [4:0] S_DEAD = 5'h04;
  localparam [4:0] S_RECL = 5'h08;
  localparam [4:0] S_LOCK = 5'h10;

  localparam [23:0] TICK_LAST = TICK_CYC - 1;
  localparam [TW-1:0] LOCK_T = `ARSEQ_LOCK_TICKS;
  localparam [3:0] SHOT_MAX = `ARSEQ_MAX_SHOTS;

  // Count of set bits in three
  function [1:0] pop3;
    input [2:0] v;
    begin
      pop3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    end
  endfunction

  // Trip decision: {final, single_pole, pole_mask}
  function [4:0] decide;
    input [1:0] prog;
    input sp_opt;
    input two_en;
    input ph_known;
    input [2:0] pick;
    input earth;
    reg [1:0] n;
    reg sp_ok;
    reg [2:0] low;
    begin
      n = pop3(pick);
      low = pick[0] ? 3'h1 : (pick[1] ? 3'h2 : 3'h4);
      sp_ok = (prog != `ARSEQ_PROG_3P) && sp_opt && ph_known &&
              (n == 2'h1 || (n == 2'h2 && !earth && two_en));
      if (sp_ok)
        decide = {2'b01, low};
      else if (prog == `ARSEQ_PROG_1P)
        decide = {2'b10, 3'h7};
      else
        decide = {2'b00, 3'h7};
    end
  endfunction

  // Attempt limit clamped to one through eight
  function [3:0] shot_lim;
    input [3:0] f;
    begin
      if (f == 4'h0)
        shot_lim = 4'h1;
      else if (f > SHOT_MAX)
        shot_lim = SHOT_MAX;
      else
        shot_lim = f;
    end
  endfunction

  // Registers
  reg [31:0] ctrl_r;
  reg [TW-1:0] dt_sp_r;
  reg [TW-1:0] dt_tp_r;
  reg [TW-1:0] dt_2p_r;
  reg [TW-1:0] reclaim_r;
  reg clr_r;
  // Sequencer state
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [2:0] mask_r;
  reg [2:0] mask_nxt;
  reg sp_r;
  reg sp_nxt;
  reg two_r;
  reg two_nxt;
  reg [3:0] shots_r;
  reg [3:0] shots_nxt;
  reg force_r;
  reg force_nxt;
  reg close_nxt;
  reg [2:0] trip_nxt;
  reg ld;
  reg [TW-1:0] ldv;
  reg [4:0] dec;
  reg [23:0] tick_cnt_r;
  reg tick_r;
  wire tmr_done;

  // Control fields
  wire en = ctrl_r[`ARSEQ_CTRL_EN];
  wire [1:0] prog = ctrl_r[`ARSEQ_CTRL_PROG_HI:`ARSEQ_CTRL_PROG_LO];
  wire tp_allow = ctrl_r[`ARSEQ_CTRL_TP_ALLOW];
  wire sp_opt = ctrl_r[`ARSEQ_CTRL_SP_OPT];
  wire two_en = ctrl_r[`ARSEQ_CTRL_TWO_PH];
  wire forced = ctrl_r[`ARSEQ_CTRL_FORCED];
  wire pickup = ctrl_r[`ARSEQ_CTRL_PICKUP];
  wire per_pole = ctrl_r[`ARSEQ_CTRL_PER_POLE];
  wire [3:0] shot_cfg = shot_lim(ctrl_r[`ARSEQ_CTRL_SHOT_HI:`ARSEQ_CTRL_SHOT_LO]);

  // Breaker position from pole or series contacts
  wire all_closed = per_pole ? (&cb_pole_closed) : cb_3p_closed;
  wire [1:0] open_cnt = per_pole ? pop3(~cb_pole_closed) :
                        (cb_3p_open ? 2'h3 : (cb_3p_closed ? 2'h0 : 2'h1));
  wire ready = en && !ar_block && all_closed;

  // Dead time for the cycle kind and fault type
  wire [TW-1:0] dead_sel = sp_r ? dt_sp_r :
                           ((pickup && two_r) ? dt_2p_r : dt_tp_r);
  wire [TW-1:0] dead_tp = (pickup && two_r) ? dt_2p_r : dt_tp_r;

  // APB handshake
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire addr_ok = (paddr == `ARSEQ_OFS_CTRL) || (paddr == `ARSEQ_OFS_DT_SP) ||
                 (paddr == `ARSEQ_OFS_DT_TP) || (paddr == `ARSEQ_OFS_DT_2P) ||
                 (paddr == `ARSEQ_OFS_RECLAIM) || (paddr == `ARSEQ_OFS_STATUS);

  // Time base prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h000001;
      tick_r <= 1'b0;
    end
  end

  // Shared timer for dead, reclaim and lockout
  arseq_timer #(
    .TW(TW)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr_r),
    .tick(tick_r),
    .load(ld),
    .load_val(ldv),
    .done(tmr_done)
  );

  // APB register writes and read answers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `ARSEQ_RST_CTRL;
      dt_sp_r <= `ARSEQ_RST_DT_SP;
      dt_tp_r <= `ARSEQ_RST_DT_TP;
      dt_2p_r <= `ARSEQ_RST_DT_2P;
      reclaim_r <= `ARSEQ_RST_RECLAIM;
      clr_r <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      clr_r <= 1'b0;
      if (apb_setup) begin
        case (paddr)
          `ARSEQ_OFS_CTRL: prdata <= {18'h00000, ctrl_r[13], 1'b0, ctrl_r[11:0]};
          `ARSEQ_OFS_DT_SP: prdata <= {16'h0000, dt_sp_r};
          `ARSEQ_OFS_DT_TP: prdata <= {16'h0000, dt_tp_r};
          `ARSEQ_OFS_DT_2P: prdata <= {16'h0000, dt_2p_r};
          `ARSEQ_OFS_RECLAIM: prdata <= {16'h0000, reclaim_r};
          `ARSEQ_OFS_STATUS: prdata <= {16'h0000, shots_r, mask_r, sp_r, force_r, state_r};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (apb_wr) begin
        case (paddr)
          `ARSEQ_OFS_CTRL: begin
            ctrl_r <= {18'h00000, pwdata[13], 1'b0, pwdata[11:0]};
            clr_r <= pwdata[`ARSEQ_CTRL_CLEAR];
          end
          `ARSEQ_OFS_DT_SP: dt_sp_r <= pwdata[TW-1:0];
          `ARSEQ_OFS_DT_TP: dt_tp_r <= pwdata[TW-1:0];
          `ARSEQ_OFS_DT_2P: dt_2p_r <= pwdata[TW-1:0];
          `ARSEQ_OFS_RECLAIM: reclaim_r <= pwdata[TW-1:0];
          default: clr_r <= 1'b0;
        endcase
      end
    end
  end

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    mask_nxt = mask_r;
    sp_nxt = sp_r;
    two_nxt = two_r;
    shots_nxt = shots_r;
    force_nxt = force_r;
    close_nxt = close_cmd;
    ld = 1'b0;
    ldv = {TW{1'b0}};
    dec = decide(prog, sp_opt, two_en, prot_phase_sel, pick_phase, pick_earth);
    case (state_r)
      S_IDLE: begin
        close_nxt = 1'b0;
        shots_nxt = 4'h0;
        force_nxt = 1'b0;
        // Same enabled-stage trip input serves every fault type
        if (prot_trip && ready) begin
          mask_nxt = dec[2:0];
          sp_nxt = dec[3];
          two_nxt = (pop3(pick_phase) == 2'h2);
          if (dec[4]) begin
            state_nxt = S_LOCK;
            ld = 1'b1;
            ldv = LOCK_T;
          end else begin
            state_nxt = S_TRIP;
          end
        end
      end
      S_TRIP: begin
        if (ar_block) begin
          state_nxt = S_LOCK;
          force_nxt = sp_r && forced;
          ld = 1'b1;
          ldv = LOCK_T;
        end else if (!prot_trip || open_cnt != 2'h0) begin
          state_nxt = S_DEAD;
          ld = 1'b1;
          ldv = dead_sel;
        end
      end
      S_DEAD: begin
        if (ar_block) begin
          state_nxt = S_LOCK;
          force_nxt = sp_r && forced;
          ld = 1'b1;
          ldv = LOCK_T;
        end else if (sp_r && per_pole && open_cnt == 2'h2 && forced) begin
          state_nxt = S_LOCK;
          force_nxt = 1'b1;
          ld = 1'b1;
          ldv = LOCK_T;
        end else if (sp_r && open_cnt >= 2'h2) begin
          if (tp_allow) begin
            sp_nxt = 1'b0;
            mask_nxt = 3'h7;
            ld = 1'b1;
            ldv = dead_tp;
          end else begin
            state_nxt = S_LOCK;
            ld = 1'b1;
            ldv = LOCK_T;
          end
        end else if (tmr_done) begin
          state_nxt = S_RECL;
          close_nxt = 1'b1;
          shots_nxt = shots_r + 4'h1;
          ld = 1'b1;
          ldv = reclaim_r;
        end
      end
      S_RECL: begin
        if (all_closed)
          close_nxt = 1'b0;
        if (ar_block) begin
          state_nxt = S_LOCK;
          close_nxt = 1'b0;
          ld = 1'b1;
          ldv = LOCK_T;
        end else if (prot_trip) begin
          close_nxt = 1'b0;
          mask_nxt = 3'h7;
          if (shots_r < shot_cfg && !dec[4]) begin
            state_nxt = S_TRIP;
            mask_nxt = dec[2:0];
            sp_nxt = dec[3];
            two_nxt = (pop3(pick_phase) == 2'h2);
          end else begin
            state_nxt = S_LOCK;
            ld = 1'b1;
            ldv = LOCK_T;
          end
        end else if (tmr_done) begin
          state_nxt = S_IDLE;
          close_nxt = 1'b0;
        end
      end
      S_LOCK: begin
        close_nxt = 1'b0;
        if (open_cnt == 2'h3)
          force_nxt = 1'b0;
        // Trip still present at expiry: re-arm a zero wait and poll again
        if (tmr_done && !prot_trip) begin
          state_nxt = S_IDLE;
        end else if (tmr_done) begin
          state_nxt = S_LOCK;
          ld = 1'b1;
          ldv = {TW{1'b0}};
        end
      end
      default: begin
        state_nxt = S_IDLE;
        close_nxt = 1'b0;
      end
    endcase
  end

  // Trip command toward the breaker poles
  always @* begin
    trip_nxt = 3'h0;
    if ((state_nxt == S_TRIP || state_nxt == S_DEAD) && prot_trip)
      trip_nxt = mask_nxt;
    else if (state_nxt == S_LOCK && (prot_trip || force_nxt))
      trip_nxt = 3'h7;
    else if (state_nxt == S_IDLE && prot_trip)
      trip_nxt = 3'h7;
  end

  // Sequencer registers and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      mask_r <= 3'h0;
      sp_r <= 1'b0;
      two_r <= 1'b0;
      shots_r <= 4'h0;
      force_r <= 1'b0;
      trip_pole <= 3'h0;
      close_cmd <= 1'b0;
      final_trip <= 1'b0;
      ar_lockout <= 1'b0;
      ar_running <= 1'b0;
      ar_ready <= 1'b0;
    end else if (clr_r) begin
      state_r <= S_IDLE;
      mask_r <= 3'h0;
      sp_r <= 1'b0;
      two_r <= 1'b0;
      shots_r <= 4'h0;
      force_r <= 1'b0;
      trip_pole <= 3'h0;
      close_cmd <= 1'b0;
      final_trip <= 1'b0;
      ar_lockout <= 1'b0;
      ar_running <= 1'b0;
      ar_ready <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      sp_r <= sp_nxt;
      two_r <= two_nxt;
      shots_r <= shots_nxt;
      force_r <= force_nxt;
      trip_pole <= trip_nxt;
      close_cmd <= close_nxt;
      final_trip <= (state_nxt == S_LOCK) && (trip_nxt != 3'h0);
      ar_lockout <= (state_nxt == S_LOCK);
      ar_running <= (state_nxt == S_TRIP) || (state_nxt == S_DEAD) ||
                    (state_nxt == S_RECL);
      ar_ready <= ready && (state_nxt == S_IDLE);
    end
  end

endmodule // arseq_top

// >>> tb/arseq_brk.sv
// Breaker model: poles follow trip and close commands after fixed delays
module arseq_brk #(
  parameter int OPEN_CYC = 3,
  parameter int CLOSE_CYC = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands
  input wire logic [2:0] trip_pole,
  input wire logic close_cmd,
  input wire logic man_close,
  // Auxiliary contacts
  output logic [2:0] cb_pole_closed,
  output logic cb_3p_closed,
  output logic cb_3p_open
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r [3];
  // Series contacts derived from the poles
  assign cb_3p_closed = &cb_pole_closed;
  assign cb_3p_open = ~|cb_pole_closed;
  // A pole never closes against its own trip command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_pole_closed <= 3'h7;
      cnt_r <= '{0, 0, 0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        logic w;
        w = trip_pole[i] ? 1'b0 : (close_cmd | man_close) ? 1'b1 : cb_pole_closed[i];
        if (w == cb_pole_closed[i]) begin
          cnt_r[i] <= 0;
        end else if (cnt_r[i] >= (w ? CLOSE_CYC : OPEN_CYC)) begin
          cb_pole_closed[i] <= w;
          cnt_r[i] <= 0;
        end else begin
          cnt_r[i] <= cnt_r[i] + 1;
        end
      end
    end
  end
endmodule // arseq_brk

// >>> tb/arseq_sva.sv
// Port checker for the reclose sequencer
module arseq_sva #(
  parameter TICK_CYC = 20000
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus handshake
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Protection and breaker
  input wire prot_trip,
  input wire ar_block,
  input wire [2:0] cb_pole_closed,
  input wire cb_3p_closed,
  // Sequencer outputs
  input wire [2:0] trip_pole,
  input wire close_cmd,
  input wire final_trip,
  input wire ar_lockout,
  input wire ar_running,
  input wire ar_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK_TICKS = 500;
  int lock_n_r;
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles spent in lockout
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_n_r <= 0;
    end else begin
      lock_n_r <= ar_lockout ? lock_n_r + 1 : 0;
    end
  end
  // Bus answers
  ready_after_a: assert property (psel && !penable |=> pready) else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  // Sequence behaviour
  start_trip_a: assert property (ar_ready && prot_trip && !ar_block |=> trip_pole != 3'h0)
    else $error("no trip on start");
  close_clean_a: assert property ($rose(close_cmd) |-> ar_running && trip_pole == 3'h0)
    else $error("close out of sequence");
  open_block_a: assert property (cb_pole_closed != 3'h7 && !cb_3p_closed |=> !ar_ready)
    else $error("ready with breaker open");
  lock_idle_a: assert property (ar_lockout |-> !ar_ready && !ar_running)
    else $error("lockout not idle");
  final_lock_a: assert property (final_trip |-> ar_lockout)
    else $error("final trip outside lockout");
  lock_span_a: assert property ($fell(ar_lockout) |-> lock_n_r >= (LOCK_TICKS - 1) * TICK_CYC)
    else $error("lockout too short");
  done_idle_a: assert property ($fell(ar_running) && !ar_lockout |-> !close_cmd && !trip_pole)
    else $error("not idle after sequence");
  // Main scenarios reached
  ok_seen_c: cover property ($fell(ar_running) && !ar_lockout);
  lock_seen_c: cover property ($rose(ar_lockout));
  err_seen_c: cover property (pslverr);
endmodule // arseq_sva
bind arseq_top arseq_sva #(.TICK_CYC(TICK_CYC)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prot_trip(prot_trip), .ar_block(ar_block),
  .cb_pole_closed(cb_pole_closed), .cb_3p_closed(cb_3p_closed), .trip_pole(trip_pole),
  .close_cmd(close_cmd), .final_trip(final_trip), .ar_lockout(ar_lockout),
  .ar_running(ar_running), .ar_ready(ar_ready)
);

// >>> tb/testbench.sv
// Self-checking bench for the reclose sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic prot_trip, prot_phase_sel, pick_earth, ar_block, cb_3p_closed, cb_3p_open, man_close;
  logic [2:0] pick_phase, cb_pole_closed, trip_pole;
  logic close_cmd, final_trip, ar_lockout, ar_running, ar_ready;
  int n_fail, compares;
  logic [31:0] rst_v [5] = '{32'h108, 32'h64, 32'h12c, 32'hc8, 32'hbb8};
  arseq_top #(.TICK_CYC(TK)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prot_trip(prot_trip), .prot_phase_sel(prot_phase_sel), .pick_phase(pick_phase),
    .pick_earth(pick_earth), .ar_block(ar_block), .cb_pole_closed(cb_pole_closed),
    .cb_3p_closed(cb_3p_closed), .cb_3p_open(cb_3p_open), .trip_pole(trip_pole),
    .close_cmd(close_cmd), .final_trip(final_trip), .ar_lockout(ar_lockout),
    .ar_running(ar_running), .ar_ready(ar_ready)
  );
  arseq_brk brk (
    .pclk(pclk), .presetn(presetn), .trip_pole(trip_pole), .close_cmd(close_cmd),
    .man_close(man_close), .cb_pole_closed(cb_pole_closed), .cb_3p_closed(cb_3p_closed),
    .cb_3p_open(cb_3p_open)
  );
  // Bus clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Status line picked by index
  function automatic logic sig(input int k);
    case (k)
      0: return close_cmd;
      1: return ar_running;
      2: return ar_lockout;
      default: return ar_ready;
    endcase
  endfunction
  // Bounded wait for a status level
  task automatic wait_on(input int k, input logic v, input int lim, output int n);
    n = 0;
    #1;
    while (sig(k) !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (sig(k) !== v) begin
      n_fail++;
      $display("wrong value at %0t: wait on line %0d timed out", $time, k);
    end
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Fault for four cycles, then cleared
  task automatic pulse(input logic [2:0] ph, input logic er, input logic ps);
    @(posedge pclk);
    prot_trip <= 1'b1;
    pick_phase <= ph;
    pick_earth <= er;
    prot_phase_sel <= ps;
    repeat (4) @(posedge pclk);
    prot_trip <= 1'b0;
    pick_phase <= 3'h0;
    #1;
  endtask
  // Reset values, unmapped place, timer setup
  task automatic s_regs();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk({rd_err, rd_val}, {1'b0, rst_v[i]});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk({rd_err, rd_val}, 33'h100000000);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h0c, 32'h14);
    apb(1'b1, 8'h10, 32'ha);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd_err, rd_val}, 33'h14);
    apb(1'b1, 8'h00, 32'h2108);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd_err, rd_val}, 33'h2108);
  endtask
  // Successful cycle with a given dead time
  task automatic run_ok(input logic [31:0] ctl, input logic [2:0] ph, input logic er,
      input logic [2:0] tp, input int dt);
    int n;
    apb(1'b1, 8'h00, ctl);
    wait_on(3, 1'b1, 200, n);
    pulse(ph, er, 1'b1);
    chk(trip_pole, tp);
    wait_on(0, 1'b1, 2000, n);
    chk(n >= (dt - 1) * TK - 6 && n <= (dt + 1) * TK + 4, 1'b1);
    wait_on(1, 1'b0, 2000, n);
    chk({ar_lockout, close_cmd, trip_pole}, 5'h0);
  endtask
  // Lockout span, open breaker blocks start, then manual close
  task automatic finish_lock();
    int n;
    wait_on(2, 1'b0, 3000, n);
    chk(n >= 490 * TK && n <= 502 * TK, 1'b1);
    repeat (3) @(posedge pclk);
    #1;
    chk({ar_ready, ar_running}, 2'h0);
    @(posedge pclk);
    man_close <= 1'b1;
    wait_on(3, 1'b1, 100, n);
    @(posedge pclk);
    man_close <= 1'b0;
  endtask
  // Three-pole trip that must be final
  task automatic run_lock(input logic [31:0] ctl, input logic [2:0] ph, input logic ps);
    int n;
    apb(1'b1, 8'h00, ctl);
    wait_on(3, 1'b1, 200, n);
    pulse(ph, 1'b1, ps);
    chk({ar_lockout, final_trip, trip_pole}, 5'h1f);
    finish_lock();
  endtask
  // Two attempts, fault in each reclaim
  task automatic s_fail();
    int n;
    apb(1'b1, 8'h00, 32'h2209);
    wait_on(3, 1'b1, 200, n);
    for (int k = 0; k < 3; k++) begin
      pulse(3'h7, 1'b1, 1'b1);
      chk({ar_lockout, final_trip, trip_pole}, k == 2 ? 5'h1f : 5'h07);
      if (k < 2) begin
        wait_on(0, 1'b1, 2000, n);
        wait_on(0, 1'b0, 100, n);
      end
    end
    finish_lock();
  endtask
  // Block in single-pole dead time
  task automatic s_forced();
    int n;
    apb(1'b1, 8'h00, 32'h215b);
    wait_on(3, 1'b1, 200, n);
    pulse(3'h1, 1'b1, 1'b1);
    chk(trip_pole, 3'h1);
    @(posedge pclk);
    ar_block <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk({ar_lockout, final_trip, trip_pole}, 5'h1f);
    @(posedge pclk);
    ar_block <= 1'b0;
    finish_lock();
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, prot_trip, pick_earth, ar_block, man_close} = '0;
    {paddr, pwdata, pick_phase} = '0;
    prot_phase_sel = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    run_ok(32'h2109, 3'h7, 1'b1, 3'h7, 5);
    run_ok(32'h2189, 3'h3, 1'b0, 3'h7, 20);
    run_ok(32'h211b, 3'h2, 1'b1, 3'h2, 8);
    run_ok(32'h213b, 3'h6, 1'b0, 3'h2, 8);
    run_ok(32'h211d, 3'h4, 1'b1, 3'h4, 8);
    run_ok(32'h211d, 3'h5, 1'b1, 3'h7, 5);
    s_fail();
    run_lock(32'h211b, 3'h3, 1'b1);
    run_lock(32'h211b, 3'h1, 1'b0);
    s_forced();
    stop_test();
  end
  // Watchdog
  initial begin
    #(40000 * 50);
    n_fail++;
    stop_test();
  end
endmodule // testbench
